// ---- verif/host_link_model.sv ----
// Purpose: Host side of the serial command link
// Assumes: Mode 3 frames of one byte, 30 ns link clock
// Notes:   Link clock stands still between frames
`timescale 1ns/1ns
module host_link_model (
    // Link pins
    output logic      sck = 1'b1,
    output logic      csN = 1'b1,
    output logic      mosi = 1'b0,
    input  wire logic miso
);
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        csN = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #15 sck = 1'b0;
            mosi = tx[i];
            #15 sck = 1'b1;
            rx[i] = miso;
        end
        #15 csN = 1'b1;
        mosi = ~mosi; // No stale bit once released
        #400;
    endtask
endmodule // host_link_model

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench of the motion command decoder
// Assumes: Host model on the link, toy engine answers strobes
// Notes:   Runs never settle; seeks and halts settle after 40 clk
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, limitInput = 1'b0, lowSpeedOpt = 1'b0, motorStopped = 1'b1;
    logic sck, csN, mosi, miso, moveStrobe, posClear, busyN, bridgesOff, rejectedFlag, unknownFlag;
    logic misoOe, statusClear, reinitPulse, limitStopStyle = 1'b1;
    logic [21:0] savedPosition;
    logic [7:0]  rx;
    motion_cmd_pkg::motion_cmd_t moveCmd, lastCmd;
    int fails = 0, checked = 0, clrCount = 0, engCnt = 0, stcCount = 0, rstCount = 0;
    host_link_model host_link_model_i (.sck(sck), .csN(csN), .mosi(mosi), .miso(miso));
    motion_command_decoder motion_command_decoder_i (.clk(clk), .nrst(nrst), .sck(sck), .csN(csN), .mosi(mosi),
        .miso(miso), .misoOe(misoOe), .motorStopped(motorStopped), .atTarget(motorStopped), .moveCmd(moveCmd),
        .currentPosition(22'h2A5C3), .moveStrobe(moveStrobe), .posClear(posClear), .savedPosition(savedPosition),
        .rateCeiling(20'h00400), .rateFloor(20'h00200), .lowSpeedOpt(lowSpeedOpt), .limitStopStyle(limitStopStyle),
        .limitInput(limitInput), .statusIn(16'h5A3C), .busyN(busyN), .bridgesOff(bridgesOff),
        .rejectedFlag(rejectedFlag), .unknownFlag(unknownFlag),
        .statusClear(statusClear), .reinitPulse(reinitPulse));
    always @(posedge clk) begin
        clrCount <= clrCount + int'(posClear);
        stcCount <= stcCount + int'(statusClear);
        rstCount <= rstCount + int'(reinitPulse);
        if (moveStrobe) lastCmd <= moveCmd;
        engCnt <= !moveStrobe ? engCnt - int'(engCnt > 0) : (moveCmd.op == motion_cmd_pkg::MOT_RUN ? -1 : 40);
        motorStopped <= !moveStrobe && (engCnt == 0 || engCnt == 1);
    end
    task automatic check(input string name, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) fails++;
        if (got !== exp) $display("unexpected %s: expected %h, seen %h", name, exp, got);
    endtask
    task automatic cmd(input logic [31:0] bytes, input int n);
        for (int i = n; i >= 0; i--) host_link_model_i.xfer(bytes[8*i +: 8], rx);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 200 && busyN !== 1'b1; i++) begin
            @(posedge clk);
            #5;
        end
        check("busyN", busyN, 1);
    endtask
    task automatic end_of_test();
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_run_limit();
        cmd(32'h8B0FFFFF, 3);
        check("runOp", lastCmd.op, motion_cmd_pkg::MOT_RUN);
        check("runRate", lastCmd.rate, 20'h00400);
        cmd(32'h69000100, 3);
        check("rejectedFlag", rejectedFlag, 1);
        @(posedge clk) #5 limitInput = 1'b1;
        repeat (12) @(posedge clk);
        check("haltOp", lastCmd.op, motion_cmd_pkg::MOT_HALT_RAMP);
        check("savedPosition", savedPosition, 22'h2A5C3);
        wait_idle();
    endtask
    task automatic t_status();
        cmd(32'hF8, 0);
        check("unknownFlag", unknownFlag, 1);
        cmd(32'hB8, 0);
        wait_idle();
        check("bridgesOff", bridgesOff, 0);
        cmd(32'hD000, 1);
        check("statusHigh", rx, 8'h5B);
        cmd(32'h00, 0);
        check("statusLow", rx, 8'hBE);
        check("rejectedFlag", rejectedFlag, 0);
        check("unknownFlag", unknownFlag, 0);
        check("statusClear", stcCount, 1);
        check("misoOe", misoOe, 0);
    endtask
    task automatic t_back_off();
        @(posedge clk) #5 lowSpeedOpt = 1'b1;
        cmd(32'h93, 0);
        check("backRate", lastCmd.rate, 20'h0014F);
        check("backDir", lastCmd.dir, 1);
        @(posedge clk) #5 limitInput = 1'b0;
        repeat (12) @(posedge clk);
        check("clearCount", clrCount, 1);
        check("haltOp", lastCmd.op, motion_cmd_pkg::MOT_HALT_INST);
        wait_idle();
    endtask
    task automatic t_limit_style();
        @(posedge clk) #5 limitStopStyle = 1'b0;
        cmd(32'h82000010, 3);
        check("runRate", lastCmd.rate, 20'h00200);
        check("runDir", lastCmd.dir, 0);
        @(posedge clk) #5 limitInput = 1'b1;
        repeat (12) @(posedge clk);
        check("haltOp", lastCmd.op, motion_cmd_pkg::MOT_HALT_INST);
        check("clearCount", clrCount, 2);
        wait_idle();
    endtask
    task automatic t_seek();
        cmd(32'hD8, 0);
        check("clearCount", clrCount, 3);
        cmd(32'h68012345, 3);
        check("seekTarget", lastCmd.target, 22'h012345);
        check("seekDir", lastCmd.dir, 0);
        wait_idle();
        cmd(32'h78, 0);
        check("savedTarget", lastCmd.target, 22'h2A5C3);
        cmd(32'h70, 0);
        check("rejectedFlag", rejectedFlag, 1);
        wait_idle();
        cmd(32'h70, 0);
        check("zeroTarget", lastCmd.target, 22'h000000);
        check("zeroShortest", lastCmd.shortest, 1);
        wait_idle();
        cmd(32'hA8, 0);
        check("bridgesOff", bridgesOff, 1);
        cmd(32'hB0, 0);
        wait_idle();
        check("bridgesOff", bridgesOff, 0);
        cmd(32'hA0, 0);
        wait_idle();
        check("bridgesOff", bridgesOff, 1);
        cmd(32'hB8, 0);
        cmd(32'hF8C0, 1);
        check("bridgesOff", bridgesOff, 1);
        check("savedPosition", savedPosition, 22'h000000);
        check("unknownFlag", unknownFlag, 0);
        check("reinitPulse", rstCount, 1);
        check("busyN", busyN, 1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #5 nrst = 1'b1;
        check("bridgesOff", bridgesOff, 1);
        t_run_limit();
        t_status();
        t_back_off();
        t_limit_style();
        t_seek();
        end_of_test();
    end
    initial forever #20 clk = ~clk;
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule // tb_top

// ---- verilog/motion_cmd_pkg.sv ----
// Purpose: Shared constants and types of the motion command decoder
// Assumes: 0.28 rate format, 250 ns motion tick
// Notes:   Opcode values carry sense and choice bits in place
package motion_cmd_pkg;
    // ========================================
    // Widths
    localparam int POS_W  = 22;
    localparam int RATE_W = 20;
    localparam int STAT_W = 16;
    // ========================================
    // Opcodes
    localparam logic [7:0] OPC_NOP        = 8'h00;
    localparam logic [7:0] OPC_SEEK_DIR   = 8'h68;
    localparam logic [7:0] SEEK_DIR_MASK  = 8'hFE;
    localparam logic [7:0] OPC_RUN_LIMIT  = 8'h82;
    localparam logic [7:0] OPC_BACK_OFF   = 8'h92;
    localparam logic [7:0] LIMIT_MASK     = 8'hF6;
    localparam logic [7:0] OPC_SEEK_ZERO  = 8'h70;
    localparam logic [7:0] OPC_SEEK_SAVED = 8'h78;
    localparam logic [7:0] OPC_ZERO_POS   = 8'hD8;
    localparam logic [7:0] OPC_REINIT     = 8'hC0;
    localparam logic [7:0] OPC_RAMP_HALT  = 8'hB0;
    localparam logic [7:0] OPC_INST_HALT  = 8'hB8;
    localparam logic [7:0] OPC_RAMP_OFF   = 8'hA0;
    localparam logic [7:0] OPC_INST_OFF   = 8'hA8;
    localparam logic [7:0] OPC_READ_FLAGS = 8'hD0;
    localparam int         SENSE_BIT      = 0;
    localparam int         CHOICE_BIT     = 3;
    localparam logic [1:0] ARG_BYTES      = 2'h3;
    localparam logic [1:0] RESP_BYTES     = 2'h2;
    // ========================================
    // Status word fields and reset values
    localparam int   STAT_BRIDGES_OFF = 0;
    localparam int   STAT_BUSY_N      = 1;
    localparam int   STAT_UNKNOWN     = 7;
    localparam int   STAT_REJECTED    = 8;
    localparam logic BRIDGES_OFF_RST  = 1'b1;
    // ========================================
    // Back-off floor rate: 5 step/s in 0.28 steps per tick
    localparam longint TICK_NS          = 250;
    localparam longint BACKOFF_SPS      = 5;
    localparam int     RATE_FRAC        = 28;
    localparam logic [RATE_W-1:0] BACKOFF_RATE =
        RATE_W'((BACKOFF_SPS * TICK_NS * (64'h1 << RATE_FRAC)) / 1000000000);
    // ========================================
    // Types
    typedef enum logic [2:0] {
        MOT_NONE, MOT_SEEK, MOT_RUN, MOT_HALT_RAMP, MOT_HALT_INST
    } motion_op_t;
    typedef enum logic [2:0] {
        PH_IDLE, PH_SEEK, PH_RUN_LIMIT, PH_BACK_OFF, PH_STOPPING
    } phase_t;
    typedef struct packed {
        motion_op_t        op;
        logic              dir;
        logic              shortest;
        logic [POS_W-1:0]  target;
        logic [RATE_W-1:0] rate;
    } motion_cmd_t;
endpackage

// ---- verilog/motion_command_decoder.sv ----
// Purpose: Byte command decoder for the homing, seek, stop and status set
// Assumes: SPI mode 3, one byte per chip-select frame, engine on clk
// Notes:   Notes on behaviour below
// Notes on behaviour
// - Directed seek goes to the absolute target, forward on sense 1, reverse on 0
// - Directed seek only while idle; otherwise ignored and rejected flag set
// - Run-to-limit runs at the given rate and sense, at any time
// - Limit turn-on clears or saves position by choice, then ramped halt
// - Rate argument is unsigned 0.28 steps per tick
// - Run-to-limit rate clamped between floor and ceiling
// - Stop style low makes the limit reaction an instant halt
// - Run-to-limit stays busy until limit hit and motor stopped
// - Back-off moves at floor rate in the given sense
// - Limit release clears or saves position by choice, then instant halt
// - Back-off uses 5 step/s when floor lower or low-speed mode set
// - Back-off stays busy until limit released and motor stopped
// - Seek-zero is a shortest-path seek to zero, busy until there
// - Seek-zero only while idle; otherwise ignored and rejected flag set
// - Seek-saved goes to saved position; rejected while busy
// - Zero-position command clears current position
// - Full reinit returns core state to power-up values; link and crossing flops keep theirs
// - Ramped halt decelerates, busy until stopped, re-enables bridges
// - Instant halt stops at once, busy until stopped, re-enables bridges
// - Ramped bridge-off stops, then disables bridges and sets the flag
// - Instant bridge-off disables bridges at once and sets the flag
// - Read-flags returns two bytes high first, clears warnings, keeps bridge flag
// - Opcode byte then up to three argument bytes, high byte first
// - Every byte not part of a response is answered with zero
// - A new response aborts an unfinished one
// - Unknown opcodes are ignored and raise the unknown flag
`timescale 1ns/1ns
module motion_command_decoder (
    // System
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Serial command link
    input  wire logic                          sck,
    input  wire logic                          csN,
    input  wire logic                          mosi,
    output logic                               miso,
    output logic                               misoOe,
    // Motion engine
    input  wire logic                          motorStopped,
    input  wire logic                          atTarget,
    input  wire logic [motion_cmd_pkg::POS_W-1:0]  currentPosition,
    output motion_cmd_pkg::motion_cmd_t        moveCmd,
    output logic                               moveStrobe,
    output logic                               posClear,
    output logic [motion_cmd_pkg::POS_W-1:0]   savedPosition,
    // Configuration
    input  wire logic [motion_cmd_pkg::RATE_W-1:0] rateCeiling,
    input  wire logic [motion_cmd_pkg::RATE_W-1:0] rateFloor,
    input  wire logic                          lowSpeedOpt,
    input  wire logic                          limitStopStyle,
    input  wire logic                          limitInput,
    // Status
    input  wire logic [motion_cmd_pkg::STAT_W-1:0] statusIn,
    output logic                               busyN,
    output logic                               bridgesOff,
    output logic                               rejectedFlag,
    output logic                               unknownFlag,
    output logic                               statusClear,
    output logic                               reinitPulse
);
    // ========================================
    // Link domain: shift in on rising, out on falling edge
    logic [2:0] bitCnt;
    logic [6:0] rxShift;
    logic [7:0] rxByte;
    logic       rxToggle;
    logic [7:0] txShift;
    logic [7:0] txByte;
    wire        frameRst = csN | ~nrst;

    always_ff @(posedge sck or posedge frameRst) begin
        if (frameRst) begin
            bitCnt  <= 3'h0;
            rxShift <= 7'h00;
        end else begin
            bitCnt  <= bitCnt + 3'h1;
            rxShift <= {rxShift[5:0], mosi};
        end
    end

    // Byte is held until the next byte completes, so the core reads it stable
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            rxByte   <= 8'h00;
            rxToggle <= 1'b0;
        end else if (bitCnt == 3'h7 && !csN) begin
            rxByte   <= {rxShift, mosi};
            rxToggle <= ~rxToggle;
        end
    end

    // txByte only changes between frames, so the first falling edge sees it settled
    always_ff @(negedge sck or posedge frameRst) begin
        if (frameRst) begin
            txShift <= 8'h00;
        end else if (bitCnt == 3'h0) begin
            txShift <= txByte;
        end else begin
            txShift <= {txShift[6:0], 1'b0};
        end
    end
    assign miso   = txShift[7];
    assign misoOe = ~csN;

    // ========================================
    // Crossings and power-up-only state
    logic rxSync1, rxSync2, rxSeen;
    logic limS1, limS2, limPrev;
    logic wipeQ;
    wire  rxEvt    = rxSync2 ^ rxSeen;
    wire  coreRstN = nrst & ~wipeQ;
    logic fire;
    logic isReinit;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxSync1 <= 1'b0;
            rxSync2 <= 1'b0;
            rxSeen  <= 1'b0;
            limS1   <= 1'b0;
            limS2   <= 1'b0;
            limPrev <= 1'b0;
            wipeQ   <= 1'b0;
        end else begin
            rxSync1 <= rxToggle;
            rxSync2 <= rxSync1;
            rxSeen  <= rxSync2;
            limS1   <= limitInput;
            limS2   <= limS1;
            limPrev <= limS2;
            wipeQ   <= fire & isReinit;
        end
    end
    assign reinitPulse = wipeQ;

    // ========================================
    // Byte assembly
    logic [7:0]  opcode;
    logic [23:0] argAcc;
    logic [1:0]  argLeft;
    // Back-off is a single byte; counting arguments for it would swallow later commands
    wire  inTakesArgs = ((rxByte & motion_cmd_pkg::SEEK_DIR_MASK) == motion_cmd_pkg::OPC_SEEK_DIR)
                      | ((rxByte & motion_cmd_pkg::LIMIT_MASK) == motion_cmd_pkg::OPC_RUN_LIMIT);

    always_ff @(posedge clk or negedge coreRstN) begin
        if (!coreRstN) begin
            opcode  <= motion_cmd_pkg::OPC_NOP;
            argAcc  <= 24'h000000;
            argLeft <= 2'h0;
            fire    <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (rxEvt && argLeft == 2'h0) begin
                opcode  <= rxByte;
                argLeft <= inTakesArgs ? motion_cmd_pkg::ARG_BYTES : 2'h0;
                fire    <= ~inTakesArgs;
            end else if (rxEvt) begin
                argAcc  <= {argAcc[15:0], rxByte};
                argLeft <= argLeft - 2'h1;
                fire    <= (argLeft == 2'h1);
            end
        end
    end

    // ========================================
    // Decode
    wire isSeekDir  = (opcode & motion_cmd_pkg::SEEK_DIR_MASK) == motion_cmd_pkg::OPC_SEEK_DIR;
    wire isRunLim   = (opcode & motion_cmd_pkg::LIMIT_MASK) == motion_cmd_pkg::OPC_RUN_LIMIT;
    wire isBackOff  = (opcode & motion_cmd_pkg::LIMIT_MASK) == motion_cmd_pkg::OPC_BACK_OFF;
    wire isSeekZero = opcode == motion_cmd_pkg::OPC_SEEK_ZERO;
    wire isSeekSave = opcode == motion_cmd_pkg::OPC_SEEK_SAVED;
    wire isZeroPos  = opcode == motion_cmd_pkg::OPC_ZERO_POS;
    wire isRampHalt = opcode == motion_cmd_pkg::OPC_RAMP_HALT;
    wire isInstHalt = opcode == motion_cmd_pkg::OPC_INST_HALT;
    wire isRampOff  = opcode == motion_cmd_pkg::OPC_RAMP_OFF;
    wire isInstOff  = opcode == motion_cmd_pkg::OPC_INST_OFF;
    wire isRead     = opcode == motion_cmd_pkg::OPC_READ_FLAGS;
    wire isNop      = opcode == motion_cmd_pkg::OPC_NOP;
    assign isReinit = opcode == motion_cmd_pkg::OPC_REINIT;
    wire isUnknown  = ~(isSeekDir | isRunLim | isBackOff | isSeekZero | isSeekSave | isZeroPos
                      | isRampHalt | isInstHalt | isRampOff | isInstOff | isRead | isNop | isReinit);

    motion_cmd_pkg::phase_t phase, next_phase;
    wire busy      = phase != motion_cmd_pkg::PH_IDLE;
    wire seekGated = isSeekDir | isSeekZero | isSeekSave;
    wire doReject  = fire & seekGated & busy;
    wire doSeek    = fire & seekGated & ~busy;
    wire doRead    = fire & isRead;
    wire opDir     = opcode[motion_cmd_pkg::SENSE_BIT];
    wire opAct     = opcode[motion_cmd_pkg::CHOICE_BIT];

    // Rate is 0.28 fixed point, passed on in its own format
    wire [motion_cmd_pkg::RATE_W-1:0] argRate = argAcc[motion_cmd_pkg::RATE_W-1:0];
    wire [motion_cmd_pkg::POS_W-1:0]  argPos  = argAcc[motion_cmd_pkg::POS_W-1:0];
    wire [motion_cmd_pkg::RATE_W-1:0] clampRate =
        (argRate > rateCeiling) ? rateCeiling :
        (argRate < rateFloor)   ? rateFloor : argRate;
    wire slowBack = (rateFloor < motion_cmd_pkg::BACKOFF_RATE) | lowSpeedOpt;
    wire [motion_cmd_pkg::RATE_W-1:0] backRate =
        slowBack ? motion_cmd_pkg::BACKOFF_RATE : rateFloor;

    logic actLatch;
    logic offPending;
    wire  limitRise  = limS2 & ~limPrev;
    wire  limitFall  = ~limS2 & limPrev;
    wire  limitHit   = (phase == motion_cmd_pkg::PH_RUN_LIMIT) & limitRise & ~fire;
    wire  releaseHit = (phase == motion_cmd_pkg::PH_BACK_OFF) & limitFall & ~fire;
    wire  posEvent   = limitHit | releaseHit;
    // Engine flags are ignored for one cycle after a new order reaches it
    wire  settled    = motorStopped & ~moveStrobe;

    // ========================================
    // Motion sequencing
    motion_cmd_pkg::motion_cmd_t next_cmd;
    logic issue;

    always_comb begin
        next_phase = phase;
        next_cmd   = moveCmd;
        issue      = 1'b0;
        if (doSeek) begin
            next_phase        = motion_cmd_pkg::PH_SEEK;
            issue             = 1'b1;
            next_cmd.op       = motion_cmd_pkg::MOT_SEEK;
            next_cmd.dir      = opDir;
            next_cmd.shortest = ~isSeekDir;
            next_cmd.target   = isSeekDir ? argPos :
                                isSeekSave ? savedPosition : '0;
        end else if (fire & isRunLim) begin
            next_phase    = motion_cmd_pkg::PH_RUN_LIMIT;
            issue         = 1'b1;
            next_cmd.op   = motion_cmd_pkg::MOT_RUN;
            next_cmd.dir  = opDir;
            next_cmd.rate = clampRate;
        end else if (fire & isBackOff) begin
            next_phase    = motion_cmd_pkg::PH_BACK_OFF;
            issue         = 1'b1;
            next_cmd.op   = motion_cmd_pkg::MOT_RUN;
            next_cmd.dir  = opDir;
            next_cmd.rate = backRate;
        end else if (fire & (isRampHalt | isRampOff)) begin
            next_phase  = motion_cmd_pkg::PH_STOPPING;
            issue       = 1'b1;
            next_cmd.op = motion_cmd_pkg::MOT_HALT_RAMP;
        end else if (fire & (isInstHalt | isInstOff)) begin
            next_phase  = motion_cmd_pkg::PH_STOPPING;
            issue       = 1'b1;
            next_cmd.op = motion_cmd_pkg::MOT_HALT_INST;
        end else if (limitHit) begin
            next_phase  = motion_cmd_pkg::PH_STOPPING;
            issue       = 1'b1;
            next_cmd.op = limitStopStyle ? motion_cmd_pkg::MOT_HALT_RAMP
                                         : motion_cmd_pkg::MOT_HALT_INST;
        end else if (releaseHit) begin
            next_phase  = motion_cmd_pkg::PH_STOPPING;
            issue       = 1'b1;
            next_cmd.op = motion_cmd_pkg::MOT_HALT_INST;
        end else begin
            unique case (phase)
                motion_cmd_pkg::PH_SEEK: begin
                    if (settled & atTarget) begin
                        next_phase = motion_cmd_pkg::PH_IDLE;
                    end
                end
                motion_cmd_pkg::PH_STOPPING: begin
                    if (settled) begin
                        next_phase = motion_cmd_pkg::PH_IDLE;
                    end
                end
                motion_cmd_pkg::PH_IDLE,
                motion_cmd_pkg::PH_RUN_LIMIT,
                motion_cmd_pkg::PH_BACK_OFF: begin
                    next_phase = phase;
                end
                default: begin
                    next_phase = motion_cmd_pkg::PH_IDLE;
                end
            endcase
        end
    end

    wire stopDone = (phase == motion_cmd_pkg::PH_STOPPING) & (next_phase == motion_cmd_pkg::PH_IDLE);
    wire newMove  = fire & (doSeek | isRunLim | isBackOff | isRampHalt | isInstHalt | isInstOff);

    always_ff @(posedge clk or negedge coreRstN) begin
        if (!coreRstN) begin
            phase      <= motion_cmd_pkg::PH_IDLE;
            moveCmd    <= '0;
            moveStrobe <= 1'b0;
        end else begin
            phase      <= next_phase;
            moveCmd    <= next_cmd;
            moveStrobe <= issue;
        end
    end
    assign busyN = ~busy;

    // ========================================
    // Position, bridges and flags
    always_ff @(posedge clk or negedge coreRstN) begin
        if (!coreRstN) begin
            actLatch      <= 1'b0;
            posClear      <= 1'b0;
            savedPosition <= '0;
        end else begin
            if (fire & (isRunLim | isBackOff)) begin
                actLatch <= opAct;
            end
            posClear <= (fire & isZeroPos) | (posEvent & ~actLatch);
            if (posEvent & actLatch) begin
                savedPosition <= currentPosition;
            end
        end
    end

    always_ff @(posedge clk or negedge coreRstN) begin
        if (!coreRstN) begin
            bridgesOff <= motion_cmd_pkg::BRIDGES_OFF_RST;
            offPending <= 1'b0;
        end else begin
            if (fire & (isRampHalt | isInstHalt)) begin
                bridgesOff <= 1'b0;
            end else if ((fire & isInstOff) | (stopDone & offPending)) begin
                bridgesOff <= 1'b1;
            end
            if (fire & isRampOff) begin
                offPending <= 1'b1;
            end else if (newMove | stopDone) begin
                offPending <= 1'b0;
            end
        end
    end

    // Set wins over the read that clears
    always_ff @(posedge clk or negedge coreRstN) begin
        if (!coreRstN) begin
            rejectedFlag <= 1'b0;
            unknownFlag  <= 1'b0;
            statusClear  <= 1'b0;
        end else begin
            rejectedFlag <= doReject | (rejectedFlag & ~doRead);
            unknownFlag  <= (fire & isUnknown) | (unknownFlag & ~doRead);
            statusClear  <= doRead;
        end
    end

    // ========================================
    // Response buffer
    logic [15:0] respBuf;
    logic [1:0]  respCnt;
    logic [motion_cmd_pkg::STAT_W-1:0] statusWord;

    always_comb begin
        statusWord = statusIn;
        statusWord[motion_cmd_pkg::STAT_BRIDGES_OFF] = bridgesOff;
        statusWord[motion_cmd_pkg::STAT_BUSY_N]      = busyN;
        statusWord[motion_cmd_pkg::STAT_UNKNOWN]     = unknownFlag;
        statusWord[motion_cmd_pkg::STAT_REJECTED]    = rejectedFlag;
    end

    always_ff @(posedge clk or negedge coreRstN) begin
        if (!coreRstN) begin
            respBuf <= 16'h0000;
            respCnt <= 2'h0;
        end else if (doRead) begin
            respBuf <= statusWord;
            respCnt <= motion_cmd_pkg::RESP_BYTES;
        end else if (rxEvt && respCnt != 2'h0) begin
            respBuf <= {respBuf[7:0], 8'h00};
            respCnt <= respCnt - 2'h1;
        end
    end
    assign txByte = (respCnt != 2'h0) ? respBuf[15:8] : 8'h00;

    // ========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!coreRstN);

    a_seek_reject: assert property (fire && seekGated && busy |=> rejectedFlag && !moveStrobe)
        else $error("busy seek not rejected");
    a_seek_start: assert property (doSeek && isSeekDir |=> moveStrobe && moveCmd.op == motion_cmd_pkg::MOT_SEEK
        && moveCmd.dir == $past(opDir) && moveCmd.target == $past(argPos))
        else $error("directed seek not issued");
    a_zero_seek: assert property (doSeek && isSeekZero |=> moveCmd.target == '0 && moveCmd.shortest)
        else $error("seek to zero wrong");
    a_run_clamp: assert property (fire && isRunLim && rateFloor <= rateCeiling
        |=> moveCmd.rate <= rateCeiling && moveCmd.rate >= rateFloor)
        else $error("run rate outside limits");
    a_back_rate: assert property (fire && isBackOff && lowSpeedOpt
        |=> moveCmd.rate == motion_cmd_pkg::BACKOFF_RATE)
        else $error("back-off rate not floor");
    a_limit_halt: assert property (limitHit && !limitStopStyle
        |=> moveStrobe && moveCmd.op == motion_cmd_pkg::MOT_HALT_INST)
        else $error("instant halt missing");
    a_limit_clear: assert property (posEvent && !actLatch |=> posClear)
        else $error("position not cleared");
    a_busy_hold: assert property (phase == motion_cmd_pkg::PH_RUN_LIMIT && !fire && !limitHit
        |=> busyN == 1'b0)
        else $error("busy released early");
    a_bridge_off: assert property (fire && isInstOff |=> bridgesOff ##1 bridgesOff)
        else $error("bridges not off");
    a_read_keep: assert property (doRead |=> bridgesOff == $past(bridgesOff) && respCnt == 2'h2)
        else $error("read disturbed bridge flag");
    a_unknown_op: assert property (fire && isUnknown |=> unknownFlag && !moveStrobe)
        else $error("unknown opcode not flagged");

    c_seek: cover property (doSeek ##[1:50] phase == motion_cmd_pkg::PH_IDLE);
    c_limit: cover property (limitHit);
    c_release: cover property (releaseHit);
    c_read: cover property (doRead);
endmodule // motion_command_decoder
